// [core/spcs_pkg.sv]
// Constants shared by the serial-port configuration and status block.
package spcs_pkg;
    // ****************************************************************
    // Register map and field positions.
    // ****************************************************************
    localparam logic [7:0] SPCS_CFG_ADDR = 8'hA1;
    localparam int SPCS_BIT_BUSY = 7;
    localparam int SPCS_BIT_MST = 6;
    localparam int SPCS_BIT_CPHA = 5;
    localparam int SPCS_BIT_CPOL = 4;
    localparam int SPCS_BIT_SEL = 3;
    localparam int SPCS_BIT_RAW = 2;
    localparam int SPCS_BIT_SHIFTER_EMPTY_FLAG = 1;
    localparam int SPCS_BIT_RECEIVE_BUFFER_EMPTY_FLAG = 0;
    localparam logic [7:0] SPCS_CFG_RESET = 8'h07;
    localparam logic [7:0] SPCS_WR_MASK = 8'h70;
    // ****************************************************************
    // Timing counts in system clock cycles, and the number of bits per frame.
    // ****************************************************************
    localparam int SPCS_SCK_HALF_CYC = 2;
    localparam int SPCS_DGL_CYC = 4;
    localparam int SPCS_BITS = 8;
endpackage : spcs_pkg

// [core/spcs_core.sv]
// Serial-port configuration and status register with its shift engine.
// Operation
// - Busy flag bit 7 is high while any transfer runs, master or slave.
// - Bit 6 selects slave operation at 0, master operation at 1.
// - Bit 5 centres data on first clock edge at 0, second at 1.
// - Bit 4 makes the serial clock idle low at 0, high at 1.
// - Bit 3 reads 1 while select input is low, 0 while high.
// - Slave-selected flag follows a de-glitched copy of the select input.
// - Bit 2 returns the unfiltered select input level when read.
// - In slave, bit 1 rises when shifter is done and nothing waits.
// - Bit 1 falls on a transmit load or a sampling edge of the serial clock.
// - In slave, bit 0 is 1 after reading, 0 when new data arrives.
// - As master, bits 1 and 0 both read as 1.
// - As slave, incoming data is sampled at the middle of each bit.
// - As master, incoming data is sampled in the last cycle of each bit.
`timescale 1ns/1ps
module spcs_core import spcs_pkg::*; #(
    parameter int SCK_HALF = SPCS_SCK_HALF_CYC,
    parameter int DGL_CYC = SPCS_DGL_CYC
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_tx_wr,
    input wire logic [7:0] i_tx_data,
    input wire logic i_rx_rd,
    output logic [7:0] o_rx_data,
    input wire logic i_link_sck,
    input wire logic i_nss,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic i_miso,
    output logic o_sck,
    output logic o_sck_oe,
    output logic o_mosi,
    output logic o_mosi_oe
);
    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    if (SCK_HALF < 1 || SCK_HALF > 127) begin : g_bad_half
        $error("SCK_HALF out of range");
    end
    if (DGL_CYC < 2 || DGL_CYC > 15) begin : g_bad_dgl
        $error("DGL_CYC out of range");
    end
    localparam logic [7:0] HALF = 8'(SCK_HALF);
    localparam logic [7:0] PH_LAST = 8'(2 * SCK_HALF - 1);
    localparam logic [3:0] DGL_LAST = 4'(DGL_CYC - 1);
    localparam logic [2:0] BIT_LAST = 3'(SPCS_BITS - 1);

    // ****************************************************************
    // Register file.
    // ****************************************************************
    logic [7:0] ctl_q;
    logic shifter_empty_flag_q;
    logic receive_buffer_empty_flag_q;
    logic slave_selected_flag_q;
    logic nss_s1_q;
    logic nss_s2_q;
    logic m_act_q;
    logic [7:0] rdata_q;
    wire cfg_hit = (i_sfr_addr == SPCS_CFG_ADDR);
    wire cfg_wr = i_sfr_wr & cfg_hit;
    wire mst = ctl_q[SPCS_BIT_MST];
    wire cpha = ctl_q[SPCS_BIT_CPHA];
    wire cpol = ctl_q[SPCS_BIT_CPOL];
    wire busy = mst ? m_act_q : (slave_selected_flag_q & ~shifter_empty_flag_q);
    wire [7:0] stat = {busy, mst, cpha, cpol, slave_selected_flag_q, nss_s2_q,
        shifter_empty_flag_q | mst, receive_buffer_empty_flag_q | mst};
    // Only the mode bits are writable; status bits keep their hardware value.
    wire [7:0] ctl_d = cfg_wr ? (i_sfr_wdata & SPCS_WR_MASK) : ctl_q;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_q <= SPCS_CFG_RESET & SPCS_WR_MASK;
            rdata_q <= 8'h00;
        end else begin
            ctl_q <= ctl_d;
            rdata_q <= (i_sfr_rd && cfg_hit) ? stat : 8'h00;
        end
    end
    assign o_sfr_rdata = rdata_q;

    // ****************************************************************
    // Select input: synchroniser and de-glitch filter.
    // ****************************************************************
    logic [3:0] dgl_q;
    wire nss_diff = (nss_s2_q == slave_selected_flag_q);
    wire [3:0] dgl_d = nss_diff ? dgl_q + 4'h1 : 4'h0;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            nss_s1_q <= 1'b1;
            nss_s2_q <= 1'b1;
            dgl_q <= 4'h0;
            slave_selected_flag_q <= 1'b0;
        end else begin
            nss_s1_q <= i_nss;
            nss_s2_q <= nss_s1_q;
            dgl_q <= (dgl_q == DGL_LAST) ? 4'h0 : dgl_d;
            if (nss_diff && dgl_q == DGL_LAST) begin
                slave_selected_flag_q <= ~nss_s2_q;
            end
        end
    end

    // ****************************************************************
    // Slave shifter on the link clock.
    // ****************************************************************
    // The sampling edge is the mid-bit edge for every mode. Change the mode
    // bits only while deselected, since they steer the link clock itself.
    wire lk_clk = i_link_sck ^ cpol ^ cpha;
    // Deselecting ends the frame, so no link edge is needed to clear it.
    wire lk_rst_n = i_reset_n & ~i_nss & ~mst;
    logic [7:0] tx_hold_q;
    logic [2:0] lk_cnt_q;
    logic [7:0] lk_rx_q;
    logic [7:0] lk_word_q;
    logic lk_done_q;
    logic lk_act_q;
    logic [7:0] lk_tx_q;

    always_ff @(posedge lk_clk or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
            lk_cnt_q <= 3'h0;
            lk_rx_q <= 8'h00;
            lk_act_q <= 1'b0;
        end else begin
            lk_cnt_q <= lk_cnt_q + 3'h1;
            lk_rx_q <= {lk_rx_q[6:0], i_mosi};
            lk_act_q <= ~lk_act_q;
        end
    end

    always_ff @(posedge lk_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lk_word_q <= 8'h00;
            lk_done_q <= 1'b0;
        end else if (lk_rst_n && lk_cnt_q == BIT_LAST) begin
            lk_word_q <= {lk_rx_q[6:0], i_mosi};
            lk_done_q <= ~lk_done_q;
        end
    end

    // The shifter is loaded from the transmit buffer at each byte boundary.
    always_ff @(negedge lk_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lk_tx_q <= 8'h00;
        end else if (lk_cnt_q == 3'h0) begin
            lk_tx_q <= tx_hold_q;
        end else begin
            lk_tx_q <= {lk_tx_q[6:0], 1'b0};
        end
    end
    assign o_miso = lk_tx_q[7];

    // ****************************************************************
    // Link events into the system clock domain.
    // ****************************************************************
    logic [2:0] done_s_q;
    logic [2:0] act_s_q;
    logic tx_pend_q;
    logic [7:0] rx_buf_q;
    wire s_done = (done_s_q[1] ^ done_s_q[2]) & ~mst;
    wire s_edge = (act_s_q[1] ^ act_s_q[2]) & ~mst;
    // Master writes feed the master engine, so the slave shifter flags stay untouched.
    wire tx_take = i_tx_wr & ~mst;
    logic m_done;
    logic [7:0] m_byte;
    wire rx_new = s_done | m_done;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_s_q <= 3'h0;
            act_s_q <= 3'h0;
        end else begin
            done_s_q <= {done_s_q[1:0], lk_done_q};
            act_s_q <= {act_s_q[1:0], lk_act_q};
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shifter_empty_flag_q <= SPCS_CFG_RESET[SPCS_BIT_SHIFTER_EMPTY_FLAG];
            receive_buffer_empty_flag_q <= SPCS_CFG_RESET[SPCS_BIT_RECEIVE_BUFFER_EMPTY_FLAG];
            tx_pend_q <= 1'b0;
            tx_hold_q <= 8'h00;
            rx_buf_q <= 8'h00;
        end else begin
            if (s_done && !tx_pend_q) begin
                shifter_empty_flag_q <= 1'b1;
            end else if (tx_take || s_edge) begin
                shifter_empty_flag_q <= 1'b0;
            end
            if (tx_take) begin
                tx_hold_q <= i_tx_data;
            end
            tx_pend_q <= tx_take | (tx_pend_q & ~s_done);
            // New data wins over a read in the same cycle.
            if (rx_new) begin
                receive_buffer_empty_flag_q <= 1'b0;
                rx_buf_q <= s_done ? lk_word_q : m_byte;
            end else if (i_rx_rd) begin
                receive_buffer_empty_flag_q <= 1'b1;
            end
        end
    end
    assign o_rx_data = rx_buf_q;

    // ****************************************************************
    // Master engine.
    // ****************************************************************
    logic [7:0] ph_q;
    logic [2:0] m_bit_q;
    logic [7:0] m_sh_q;
    logic [7:0] m_rx_q;
    logic miso_s1_q;
    logic miso_s2_q;
    logic sck_q;
    logic oe_q;
    wire m_start = i_tx_wr & mst & ~m_act_q;
    wire m_samp = m_act_q & (ph_q == PH_LAST);
    assign m_done = m_samp & (m_bit_q == BIT_LAST);
    assign m_byte = {m_rx_q[6:0], miso_s2_q};
    wire first_half = (ph_q < HALF);
    wire sck_d = cpol ^ (m_act_q & (cpha ? first_half : ~first_half));

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ph_q <= 8'h00;
            m_bit_q <= 3'h0;
            m_sh_q <= 8'h00;
            m_rx_q <= 8'h00;
            m_act_q <= 1'b0;
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
            sck_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            miso_s1_q <= i_miso;
            miso_s2_q <= miso_s1_q;
            sck_q <= sck_d;
            oe_q <= ~mst & slave_selected_flag_q;
            if (m_start) begin
                m_act_q <= 1'b1;
                m_sh_q <= i_tx_data;
                ph_q <= 8'h00;
                m_bit_q <= 3'h0;
            end else if (m_samp) begin
                m_rx_q <= m_byte;
                m_sh_q <= {m_sh_q[6:0], 1'b0};
                ph_q <= 8'h00;
                m_bit_q <= m_bit_q + 3'h1;
                m_act_q <= ~m_done;
            end else if (m_act_q) begin
                ph_q <= ph_q + 8'h01;
            end
        end
    end
    assign o_sck = sck_q;
    assign o_mosi = m_sh_q[7];
    assign o_sck_oe = ctl_q[SPCS_BIT_MST];
    assign o_mosi_oe = ctl_q[SPCS_BIT_MST];
    assign o_miso_oe = oe_q;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    // ****************************************************************
    // Helper counter: cycles spent in the current master byte.
    // ****************************************************************
    // A counter stands in for a long repetition, which the tools would unroll.
    localparam logic [11:0] M_LEN_MAX = 12'(SPCS_BITS * 2 * SCK_HALF);
    logic [11:0] m_len_q;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            m_len_q <= 12'h000;
        end else begin
            m_len_q <= m_act_q ? m_len_q + 12'h001 : 12'h000;
        end
    end

    busy_master_a: assert property (mst && m_act_q |-> stat[SPCS_BIT_BUSY])
        else $error("busy low during master transfer");
    mode_write_a: assert property (cfg_wr |=> mst == $past(i_sfr_wdata[SPCS_BIT_MST]))
        else $error("mode bit not taken");
    // The clock flop lags a polarity write by one cycle, so only a settled polarity is judged.
    sck_idle_a: assert property (mst && !m_act_q ##1 !m_act_q && $stable(cpol) |-> o_sck == cpol)
        else $error("serial clock not idle at polarity");
    sel_level_a: assert property ($changed(slave_selected_flag_q) |-> slave_selected_flag_q == !$past(nss_s2_q))
        else $error("selected flag against pin level");
    sel_filter_a: assert property ($changed(slave_selected_flag_q) |-> $past(nss_diff, 2) && $past(nss_diff))
        else $error("selected flag changed without filtering");
    raw_read_a: assert property (i_sfr_rd && cfg_hit |=> o_sfr_rdata[2] == $past(nss_s2_q))
        else $error("raw select level misread");
    tx_clear_a: assert property (tx_take && !s_done |=> !shifter_empty_flag_q)
        else $error("shifter empty flag not cleared");
    rx_arrive_a: assert property (s_done |=> !receive_buffer_empty_flag_q ##0 o_rx_data == $past(lk_word_q))
        else $error("received byte not flagged");
    master_flags_a: assert property (mst |-> stat[1:0] == 2'h3)
        else $error("master mode flags not forced");
    master_samp_a: assert property (m_samp |=> m_rx_q[0] == $past(miso_s2_q))
        else $error("master sample point wrong");
    busy_length_a: assert property (m_len_q <= M_LEN_MAX)
        else $error("master byte longer than eight bits");
    slave_busy_a: assert property (i_sfr_rd && cfg_hit && !mst && slave_selected_flag_q && !shifter_empty_flag_q |=> o_sfr_rdata[7])
        else $error("busy low during slave transfer");
    master_pins_a: assert property (o_sck_oe == mst && o_mosi_oe == mst)
        else $error("master pin enables wrong");
    sel_read_a: assert property (i_sfr_rd && cfg_hit |=> o_sfr_rdata[3] == $past(slave_selected_flag_q))
        else $error("selected flag misread");

    // The set of the empty flag wins over a clock transition in the same cycle.
    shifter_empty_flag_set_a: assert property (s_done && !tx_pend_q |=> shifter_empty_flag_q)
        else $error("shifter empty flag not set");
    edge_clear_a: assert property (s_edge && !(s_done && !tx_pend_q) |=> !shifter_empty_flag_q)
        else $error("shifter empty flag kept on clock edge");
    rx_read_a: assert property (i_rx_rd && !rx_new |=> receive_buffer_empty_flag_q)
        else $error("receive empty flag not set by read");
    ro_write_a: assert property (cfg_wr |=> (ctl_q & ~SPCS_WR_MASK) == 8'h00)
        else $error("read-only bits written");

    // Main scenarios: a master byte, a slave byte, selection, a busy slave and a drain.
    master_xfer_c: cover property (m_start ##[1:300] m_done);
    slave_busy_c: cover property (!mst && stat[SPCS_BIT_BUSY]);
    slave_drain_c: cover property (i_rx_rd ##1 receive_buffer_empty_flag_q);
    slave_byte_c: cover property (s_done ##1 !receive_buffer_empty_flag_q);
    select_c: cover property ($rose(slave_selected_flag_q));
endmodule : spcs_core

// [bench/spcs_peer.sv]
// Serial peer: a master for slave-mode frames and a slave answering master-mode transfers.
`timescale 1ns/1ps
module spcs_peer (
    input wire logic i_sck,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_link_sck,
    output logic o_nss,
    output logic o_mosi,
    output logic [7:0] o_cap
);
    logic [7:0] resp_q;
    initial begin
        o_link_sck = 1'b0;
        o_nss = 1'b1;
        o_mosi = 1'b0;
        o_miso = 1'b1;
        o_cap = 8'h00;
        resp_q = 8'h00;
    end
    // Answering slave in mode 0: the first bit is shown before the first edge.
    task automatic load(input logic [7:0] b);
        resp_q = b;
        o_miso = b[7];
    endtask : load
    always @(posedge i_sck) begin
        o_cap <= {o_cap[6:0], i_mosi};
    end
    // Shifting on the trailing edge scrambles the line after the byte, so stale bits never look valid.
    always @(negedge i_sck) begin
        resp_q = {resp_q[6:0], ~resp_q[0]};
        o_miso = resp_q[7];
    end
    // Short low pulse on the select line, narrower than the de-glitch filter.
    task automatic glitch(input int w);
        o_nss = 1'b0;
        #(w);
        o_nss = 1'b1;
    endtask : glitch
    // Mode 0 frame, MSB first; the link clock stands still at its idle level outside frames.
    task automatic frame(input logic [7:0] b, input int gap);
        o_nss = 1'b0;
        #(gap);
        for (int i = 7; i >= 0; i--) begin
            o_mosi = b[i];
            #15 o_link_sck = 1'b1;
            #15 o_link_sck = 1'b0;
        end
        #15 o_nss = 1'b1;
        o_mosi = ~o_mosi;
    endtask : frame
endmodule : spcs_peer

// [bench/spcs_core_bench.sv]
// Self-checking bench for the serial-port configuration and status block.
`timescale 1ns/1ps
module spcs_core_bench import spcs_pkg::*;;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic tx_wr = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_rd = 1'b0;
    logic [7:0] rx_data;
    logic link_sck, slave_select_input, mosi_s, miso_o, miso_oe, miso_m, sck, sck_oe, mosi_m, mosi_oe;
    logic [7:0] cap;
    int fails = 0;
    int checks = 0;
    always #5 mclk = ~mclk;
    // A longer half period gives the two-flop input sync room inside each bit.
    spcs_core #(.SCK_HALF(8), .DGL_CYC(4)) dut (.i_mclk(mclk), .i_reset_n(rst_n), .i_sfr_addr(addr),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_tx_wr(tx_wr),
        .i_tx_data(tx_data), .i_rx_rd(rx_rd), .o_rx_data(rx_data), .i_link_sck(link_sck), .i_nss(slave_select_input),
        .i_mosi(mosi_s), .o_miso(miso_o), .o_miso_oe(miso_oe), .i_miso(miso_m), .o_sck(sck),
        .o_sck_oe(sck_oe), .o_mosi(mosi_m), .o_mosi_oe(mosi_oe));
    spcs_peer peer (.i_sck(sck), .i_mosi(mosi_m), .o_miso(miso_m), .o_link_sck(link_sck),
        .o_nss(slave_select_input), .o_mosi(mosi_s), .o_cap(cap));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic write(input logic [7:0] d);
        addr = SPCS_CFG_ADDR;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask : write
    task automatic read(input logic [7:0] a, output logic [7:0] v);
        addr = a;
        rd = 1'b1;
        step(1);
        v = rdata;
        rd = 1'b0;
        step(1);
    endtask : read
    task automatic tx_pulse(input logic [7:0] d);
        tx_data = d;
        tx_wr = 1'b1;
        step(1);
        tx_wr = 1'b0;
    endtask : tx_pulse
    task automatic rx_drain();
        rx_rd = 1'b1;
        step(1);
        rx_rd = 1'b0;
    endtask : rx_drain
    task automatic summarize();
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic t_reset();
        logic [7:0] v;
        read(SPCS_CFG_ADDR, v);
        check("reset status", v, 8'h07);
        read(8'hA0, v);
        check("unmapped read", v, 8'h00);
    endtask : t_reset
    task automatic t_master();
        logic [7:0] v;
        write(8'hFF);
        read(SPCS_CFG_ADDR, v);
        check("master status", v, 8'h77);
        check("sck enable", {7'h00, sck_oe}, 8'h01);
        check("sck idle high", {7'h00, sck}, 8'h01);
        write(8'h40);
        step(2);
        check("sck idle low", {7'h00, sck}, 8'h00);
        peer.load(8'h3C);
        tx_pulse(8'hA5);
        step(1);
        tx_pulse(8'hFF);
        read(SPCS_CFG_ADDR, v);
        check("master busy", v, 8'hC7);
        for (int i = 0; i < 100 && v[7] !== 1'b0; i++) begin
            read(SPCS_CFG_ADDR, v);
        end
        step(4);
        read(SPCS_CFG_ADDR, v);
        check("master idle", v, 8'h47);
        check("master rx", rx_data, 8'h3C);
        check("peer capture", cap, 8'hA5);
        rx_drain();
        read(SPCS_CFG_ADDR, v);
        check("master drained", v, 8'h47);
    endtask : t_master
    task automatic t_slave();
        logic [7:0] v;
        write(8'h00);
        peer.glitch(20);
        step(4);
        read(SPCS_CFG_ADDR, v);
        check("glitch ignored", v, 8'h07);
        tx_pulse(8'hC3);
        fork
            peer.frame(8'h5A, 200);
            begin
                step(30);
                read(SPCS_CFG_ADDR, v);
                check("slave busy", v, 8'h89);
            end
        join
        step(10);
        read(SPCS_CFG_ADDR, v);
        check("slave done", v, 8'h04);
        check("slave rx", rx_data, 8'h5A);
        rx_drain();
        read(SPCS_CFG_ADDR, v);
        check("rx drained", v, 8'h05);
        peer.frame(8'h96, 200);
        step(10);
        read(SPCS_CFG_ADDR, v);
        check("shifter empty", v, 8'h06);
        check("slave rx again", rx_data, 8'h96);
        rx_drain();
        read(SPCS_CFG_ADDR, v);
        check("rx drained again", v, 8'h07);
        tx_pulse(8'h81);
        step(2);
        read(SPCS_CFG_ADDR, v);
        check("tx load", v, 8'h05);
    endtask : t_slave
    initial begin
        #200000;
        fails++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_master();
        t_slave();
        summarize();
    end
endmodule : spcs_core_bench
